//--- verilog/pmt_defines.svh
`ifndef PMT_DEFINES_SVH
`define PMT_DEFINES_SVH

// register indices, byte address is four times the index
`define PMT_IDX_IRQ_CTRL  8'h0b
`define PMT_IDX_FLAGS     8'h0c
`define PMT_IDX_COUNT     8'h11
`define PMT_IDX_CTRL      8'h12
`define PMT_IDX_ENABLES   8'h8c
`define PMT_IDX_PERIOD    8'h92
`define PMT_IDX_FLAG_CLR  8'h40

// reset values
`define PMT_RST_PERIOD    8'hff
`define PMT_RST_BYTE      8'h00
`define PMT_RST_NIBBLE    4'h0

// field positions
`define PMT_BIT_MATCH     1
`define PMT_CTRL_RUN      2
`define PMT_OPS_HI        6
`define PMT_OPS_LO        3
`define PMT_CPS_HI        1
`define PMT_CPS_LO        0
`define PMT_CTRL_MASK     8'h7f

// prescaler terminal counts (divide minus one)
`define PMT_PRE_LIM_1     4'h0
`define PMT_PRE_LIM_4     4'h3
`define PMT_PRE_LIM_16    4'hf

// bus fields
`define PMT_HTRANS_ACTIVE 1
`define PMT_IDX_HI        9
`define PMT_IDX_LO        2
`define PMT_HSIZE_WORD    3'h2
`define PMT_RESP_OKAY     1'b0
`define PMT_RDATA_PAD     24'h000000

`endif

//--- verilog/pmt_pkg.sv
package pmt_pkg;

   typedef enum logic [1:0] {
      BUS_ADDR = 2'b01,
      BUS_DATA = 2'b10
   } bus_state_t;

   typedef logic [7:0] byte_t;

endpackage : pmt_pkg

//--- verilog/prescale_div.sv
`timescale 1ns/10ps
`include "pmt_defines.svh"

module prescale_div
(
   // clock and reset
   input  wire logic       mclk_in,
   input  wire logic       srst_in,
   // control
   input  wire logic       clear_in,
   input  wire logic       run_in,
   input  wire logic [1:0] sel_in,
   // increment strobe
   output logic            tick_out
);

   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic [3:0] lim;

   always_comb
   begin
      // upper select bit alone picks the widest divide
      if (sel_in[1])
         lim = `PMT_PRE_LIM_16;
      else if (sel_in[0])
         lim = `PMT_PRE_LIM_4;
      else
         lim = `PMT_PRE_LIM_1;
      tick_out = run_in && !clear_in && (cnt_q == lim);
      cnt_d    = cnt_q;
      if (clear_in)
         cnt_d = `PMT_RST_NIBBLE;
      else if (run_in)
         cnt_d = (cnt_q == lim) ? `PMT_RST_NIBBLE : cnt_q + 4'h1;
   end

   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
         cnt_q <= `PMT_RST_NIBBLE;
      else
         cnt_q <= cnt_d;
   end

endmodule : prescale_div

//--- verilog/periodic_match_timer.sv
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "pmt_defines.svh"

module periodic_match_timer
(
   // clock and reset
   input  wire logic        mclk_in,
   input  wire logic        srst_in,
   // ahb-lite slave
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic [31:0]      hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   // events
   output logic             irq_out,
   output logic             match_out
);

   ////////////////////////////////////////////////////////////////////////////

   function automatic logic hit(input pmt_pkg::byte_t idx, input pmt_pkg::byte_t off);
      hit = (idx == off);
   endfunction : hit

   pmt_pkg::bus_state_t state_q;
   pmt_pkg::bus_state_t state_d;
   pmt_pkg::byte_t      idx_q;
   pmt_pkg::byte_t      idx_d;
   logic                wr_q;
   logic                wr_d;
   logic [31:0]         rdata_q;
   logic [31:0]         rdata_d;
   logic                ready_q;
   logic                ready_d;
   logic                resp_q;
   pmt_pkg::byte_t      rd_byte;
   logic                wr_stb;
   pmt_pkg::byte_t      wdata;

   pmt_pkg::byte_t      count_q;
   pmt_pkg::byte_t      count_d;
   pmt_pkg::byte_t      period_q;
   pmt_pkg::byte_t      period_d;
   pmt_pkg::byte_t      ctrl_q;
   pmt_pkg::byte_t      ctrl_d;
   pmt_pkg::byte_t      irqc_q;
   pmt_pkg::byte_t      irqc_d;
   logic [3:0]          post_q;
   logic [3:0]          post_d;
   logic                flag_q;
   logic                flag_d;
   logic                en_q;
   logic                en_d;
   logic                irq_q;
   logic                irq_d;
   logic                match_q;
   logic                match_d;
   logic                tick;
   logic                pre_clr;
   logic                match_ev;
   logic                post_done;
   logic                cnt_wr;
   logic                ctrl_wr;

   ////////////////////////////////////////////////////////////////////////////
   // bus slave: one wait state so read data leaves a flop

   assign wr_stb  = (state_q == pmt_pkg::BUS_DATA) && wr_q;
   assign wdata   = hwdata_in[7:0];
   assign cnt_wr  = wr_stb && hit(idx_q, `PMT_IDX_COUNT);
   assign ctrl_wr = wr_stb && hit(idx_q, `PMT_IDX_CTRL);

   always_comb
   begin
      rd_byte = `PMT_RST_BYTE;
      unique case (1'b1)
         hit(idx_q, `PMT_IDX_IRQ_CTRL): rd_byte = irqc_q;
         hit(idx_q, `PMT_IDX_FLAGS):    rd_byte = {6'h00, flag_q, 1'b0};
         hit(idx_q, `PMT_IDX_COUNT):    rd_byte = count_q;
         hit(idx_q, `PMT_IDX_CTRL):     rd_byte = ctrl_q & `PMT_CTRL_MASK;
         hit(idx_q, `PMT_IDX_ENABLES):  rd_byte = {6'h00, en_q, 1'b0};
         hit(idx_q, `PMT_IDX_PERIOD):   rd_byte = period_q;
         default:                       rd_byte = `PMT_RST_BYTE;
      endcase
   end

   always_comb
   begin
      state_d = state_q;
      idx_d   = idx_q;
      wr_d    = wr_q;
      rdata_d = rdata_q;
      ready_d = 1'b1;
      unique case (state_q)
         pmt_pkg::BUS_ADDR:
         begin
            if (hsel_in && htrans_in[`PMT_HTRANS_ACTIVE] && hready_in)
            begin
               state_d = pmt_pkg::BUS_DATA;
               idx_d   = haddr_in[`PMT_IDX_HI:`PMT_IDX_LO];
               // narrow writes are dropped rather than merged
               wr_d    = hwrite_in && (hsize_in == `PMT_HSIZE_WORD);
               ready_d = 1'b0;
            end
         end
         pmt_pkg::BUS_DATA:
         begin
            state_d = pmt_pkg::BUS_ADDR;
            if (!wr_q)
               rdata_d = {`PMT_RDATA_PAD, rd_byte};
         end
      endcase
   end

   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
      begin
         state_q <= pmt_pkg::BUS_ADDR;
         idx_q   <= `PMT_RST_BYTE;
         wr_q    <= 1'b0;
         rdata_q <= {`PMT_RDATA_PAD, `PMT_RST_BYTE};
         ready_q <= 1'b1;
         resp_q  <= `PMT_RESP_OKAY;
      end
      else
      begin
         state_q <= state_d;
         idx_q   <= idx_d;
         wr_q    <= wr_d;
         rdata_q <= rdata_d;
         ready_q <= ready_d;
         resp_q  <= `PMT_RESP_OKAY;
      end
   end

   assign hrdata_out    = rdata_q;
   assign hreadyout_out = ready_q;
   assign hresp_out     = resp_q;

   ////////////////////////////////////////////////////////////////////////////
   // timer core

   assign pre_clr = cnt_wr || ctrl_wr;

   prescale_div u_pre
   (
      .mclk_in  (mclk_in),
      .srst_in  (srst_in),
      .clear_in (pre_clr),
      .run_in   (ctrl_q[`PMT_CTRL_RUN]),
      .sel_in   (ctrl_q[`PMT_CPS_HI:`PMT_CPS_LO]),
      .tick_out (tick)
   );

   assign match_ev  = tick && (count_q == period_q);
   assign post_done = match_ev && (post_q == ctrl_q[`PMT_OPS_HI:`PMT_OPS_LO]);

   always_comb
   begin
      count_d  = count_q;
      period_d = period_q;
      ctrl_d   = ctrl_q;
      irqc_d   = irqc_q;
      post_d   = post_q;
      flag_d   = flag_q;
      en_d     = en_q;
      // software write beats a same-cycle increment
      if (cnt_wr)
         count_d = wdata;
      else if (tick)
         count_d = match_ev ? `PMT_RST_BYTE : count_q + 8'h01;
      if (ctrl_wr)
         ctrl_d = wdata & `PMT_CTRL_MASK;
      if (wr_stb && hit(idx_q, `PMT_IDX_PERIOD))
         period_d = wdata;
      if (wr_stb && hit(idx_q, `PMT_IDX_IRQ_CTRL))
         irqc_d = wdata;
      if (wr_stb && hit(idx_q, `PMT_IDX_ENABLES))
         en_d = wdata[`PMT_BIT_MATCH];
      if (pre_clr)
         post_d = `PMT_RST_NIBBLE;
      else if (match_ev)
         post_d = post_done ? `PMT_RST_NIBBLE : post_q + 4'h1;
      if (wr_stb && hit(idx_q, `PMT_IDX_FLAG_CLR) && wdata[`PMT_BIT_MATCH])
         flag_d = 1'b0;
      // set after clear so a coincident event is kept
      if (post_done)
         flag_d = 1'b1;
      irq_d   = flag_d && en_d;
      match_d = match_ev;
   end

   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
      begin
         count_q  <= `PMT_RST_BYTE;
         period_q <= `PMT_RST_PERIOD;
         ctrl_q   <= `PMT_RST_BYTE;
         irqc_q   <= `PMT_RST_BYTE;
         post_q   <= `PMT_RST_NIBBLE;
         flag_q   <= 1'b0;
         en_q     <= 1'b0;
         irq_q    <= 1'b0;
         match_q  <= 1'b0;
      end
      else
      begin
         count_q  <= count_d;
         period_q <= period_d;
         ctrl_q   <= ctrl_d;
         irqc_q   <= irqc_d;
         post_q   <= post_d;
         flag_q   <= flag_d;
         en_q     <= en_d;
         irq_q    <= irq_d;
         match_q  <= match_d;
      end
   end

   assign irq_out   = irq_q;
   assign match_out = match_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   logic [4:0] gap_q;
   logic [4:0] gap_d;
   logic [4:0] div_m1;

   always_comb
   begin
      gap_d = (tick || pre_clr) ? 5'h00 : ((gap_q == 5'h1f) ? gap_q : gap_q + 5'h01);
      if (ctrl_q[`PMT_CPS_HI])
         div_m1 = {1'b0, `PMT_PRE_LIM_16};
      else if (ctrl_q[`PMT_CPS_LO])
         div_m1 = {1'b0, `PMT_PRE_LIM_4};
      else
         div_m1 = {1'b0, `PMT_PRE_LIM_1};
   end

   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
         gap_q <= 5'h00;
      else
         gap_q <= gap_d;
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (srst_in);

   a_wrap_to_zero: assert property (
      tick && (count_q == period_q) && !cnt_wr |=> (count_q == 8'h00) && match_out)
      else $error("count did not wrap on period match");

   a_count_step: assert property (
      tick && (count_q != period_q) && !cnt_wr |=> count_q == $past(count_q) + 8'h01)
      else $error("count did not advance by one");

   a_period_write: assert property (
      wr_stb && hit(idx_q, `PMT_IDX_PERIOD) |=> (period_q == $past(wdata)))
      else $error("period write not stored");

   a_period_reset: assert property (
      $past(srst_in) |-> (period_q == 8'hff) && (count_q == 8'h00))
      else $error("period not all ones after reset");

   a_count_readback: assert property (
      (state_q == pmt_pkg::BUS_DATA) && !wr_q && hit(idx_q, `PMT_IDX_COUNT)
      |=> hreadyout_out && (hrdata_out == {24'h000000, $past(count_q)}))
      else $error("count read back wrong");

   a_ctrl_readback: assert property (
      (state_q == pmt_pkg::BUS_DATA) && !wr_q && hit(idx_q, `PMT_IDX_CTRL)
      |=> (hrdata_out[31:7] == 25'h0) && (hrdata_out[6:0] == $past(ctrl_q[6:0])))
      else $error("control read back wrong or bit seven set");

   a_post_flag: assert property (
      post_done |=> flag_q ##1 (irq_out == (flag_q && en_q)))
      else $error("postscale completion did not set flag");

   a_pre_divide: assert property (
      tick |-> gap_q == div_m1)
      else $error("prescaler spacing wrong");

   a_ctrl_keeps: assert property (
      ctrl_wr |=> (count_q == $past(count_q)) && (post_q == 4'h0))
      else $error("control write changed count or kept postscaler");

   a_count_write: assert property (
      cnt_wr |=> (count_q == $past(wdata)) && (post_q == 4'h0))
      else $error("count write not stored or kept postscaler");

   a_stop_holds: assert property (
      !ctrl_q[`PMT_CTRL_RUN] && !cnt_wr |=> (count_q == $past(count_q)) && !match_out)
      else $error("stopped timer moved");

   c_match: cover property (match_out);
   c_flag_set: cover property (!flag_q ##1 flag_q);
   c_irq: cover property (irq_out ##1 !irq_out);
   c_div16: cover property (tick && ctrl_q[`PMT_CPS_HI]);

endmodule : periodic_match_timer

//--- tb/periodic_match_timer_tb.sv
`timescale 1ns/10ps
`include "pmt_defines.svh"

module periodic_match_timer_tb;
   logic        mclk;
   logic        srst;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hready;
   logic        hresp;
   logic        irq;
   logic        match;
   logic [7:0]  q;
   int          num_errors = 0;
   int          num_checks = 0;
   int          nmatch     = 0;
   int          m0;
   int          n;
   int          divs [4]   = '{1, 4, 16, 16};
   int          ops [3]    = '{0, 1, 15};

   periodic_match_timer periodic_match_timer_i
   (
      .mclk_in       (mclk),
      .srst_in       (srst),
      .hsel_in       (1'b1),
      .haddr_in      (haddr),
      .htrans_in     (htrans),
      .hwrite_in     (hwrite),
      .hsize_in      (hsize),
      .hwdata_in     (hwdata),
      .hready_in     (hready),
      .hrdata_out    (hrdata),
      .hreadyout_out (hready),
      .hresp_out     (hresp),
      .irq_out       (irq),
      .match_out     (match)
   );

////////////////////////////////////////
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   always @(posedge mclk)
   begin
      if (match === 1'b1)
         nmatch <= nmatch + 1;
   end

   task complete_run;
   begin
      $display("errors %0d checks %0d", num_errors, num_checks);
      if (num_errors == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask : complete_run

   task chk(input string s, input logic [31:0] g, input logic [31:0] e);
   begin
      num_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %s exp %h got %h", s, e, g);
      end
   end
   endtask : chk

   // single ahb cycle; no fixed latency assumed, hang left to watchdog
   task bus(input logic w, input logic [7:0] i, input logic [7:0] d);
   begin
      haddr <= {22'h0, i, 2'b00};
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge mclk);
      while (hready !== 1'b1) @(posedge mclk);
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      @(posedge mclk);
      while (hready !== 1'b1) @(posedge mclk);
      q = hrdata[7:0];
   end
   endtask : bus

   task wr(input logic [7:0] i, input logic [7:0] d);
   begin
      bus(1'b1, i, d);
   end
   endtask : wr

   task rc(input string s, input logic [7:0] i, input logic [7:0] e);
   begin
      bus(1'b0, i, 8'h00);
      chk(s, {24'h0, q}, {24'h0, e});
   end
   endtask : rc

   // cycles between two match pulses
   task gap(input int e);
   begin
      n = 0;
      while (match !== 1'b1) @(posedge mclk);
      @(posedge mclk);
      while (match !== 1'b1)
      begin
         @(posedge mclk);
         n++;
      end
      chk("match gap", n + 1, e);
   end
   endtask : gap

////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge mclk);
      num_errors++;
      complete_run();
   end

   initial
   begin
      srst = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (5) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      rc("count", `PMT_IDX_COUNT, 8'h00);
      rc("period", `PMT_IDX_PERIOD, 8'hff);
      rc("ctrl", `PMT_IDX_CTRL, 8'h00);
      rc("flags", `PMT_IDX_FLAGS, 8'h00);
      rc("enables", `PMT_IDX_ENABLES, 8'h00);
      rc("irq ctrl", `PMT_IDX_IRQ_CTRL, 8'h00);
      wr(8'h20, 8'hff);
      rc("unmapped", 8'h20, 8'h00);
      wr(`PMT_IDX_IRQ_CTRL, 8'ha5);
      rc("irq ctrl", `PMT_IDX_IRQ_CTRL, 8'ha5);
      wr(`PMT_IDX_PERIOD, 8'h5a);
      rc("period", `PMT_IDX_PERIOD, 8'h5a);
      wr(`PMT_IDX_CTRL, 8'hfb);
      rc("ctrl", `PMT_IDX_CTRL, 8'h7b);
      // stopped timer: writes must not disturb the held count
      wr(`PMT_IDX_COUNT, 8'h33);
      wr(`PMT_IDX_CTRL, 8'h78);
      rc("count", `PMT_IDX_COUNT, 8'h33);
      m0 = nmatch;
      repeat (40) @(posedge mclk);
      rc("held count", `PMT_IDX_COUNT, 8'h33);
      chk("stopped matches", nmatch - m0, 0);
      wr(`PMT_IDX_PERIOD, 8'h03);
      for (int s = 0; s < 4; s++)
      begin
         wr(`PMT_IDX_CTRL, 8'h00);
         wr(`PMT_IDX_COUNT, 8'h00);
         wr(`PMT_IDX_CTRL, 8'h04 | s[7:0]);
         gap(divs[s] * 4);
      end
      wr(`PMT_IDX_PERIOD, 8'h01);
      wr(`PMT_IDX_ENABLES, 8'h02);
      foreach (ops[k])
      begin
         wr(`PMT_IDX_CTRL, 8'h00);
         wr(`PMT_IDX_COUNT, 8'h00);
         wr(`PMT_IDX_FLAG_CLR, 8'h02);
         wr(`PMT_IDX_CTRL, {1'b0, ops[k][3:0], 3'b100});
         n = 0;
         while (irq !== 1'b1)
         begin
            @(posedge mclk);
            if (match === 1'b1)
               n++;
         end
         chk("postscale", n, ops[k] + 1);
      end
      wr(`PMT_IDX_CTRL, 8'h00);
      rc("flags", `PMT_IDX_FLAGS, 8'h02);
      chk("irq set", irq, 1'b1);
      wr(`PMT_IDX_ENABLES, 8'h00);
      rc("enables", `PMT_IDX_ENABLES, 8'h00);
      chk("irq masked", irq, 1'b0);
      wr(`PMT_IDX_FLAG_CLR, 8'h02);
      rc("flags", `PMT_IDX_FLAGS, 8'h00);
      // reset in mid-run must bring back the defaults
      wr(`PMT_IDX_PERIOD, 8'h42);
      wr(`PMT_IDX_CTRL, 8'h04);
      srst <= 1'b1;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      rc("period", `PMT_IDX_PERIOD, 8'hff);
      rc("count", `PMT_IDX_COUNT, 8'h00);
      rc("ctrl", `PMT_IDX_CTRL, 8'h00);
      chk("irq reset", irq, 1'b0);
      chk("hresp", hresp, 1'b0);
      complete_run();
   end
endmodule : periodic_match_timer_tb
